/* modem_net_map.svh */
// register-free constant map for the modem network block
`ifndef MODEM_NET_MAP_SVH
`define MODEM_NET_MAP_SVH
`define RATE_MAX          2'h0
`define RATE_SLOTS        2'h1
`define RATE_LOW_AIR      2'h2
`define CLK_MHZ           250
`define TICK_10MS_NS      10000000
`define SLOT_GAP_NS       3400000
`define LOW_AIR_GAP_NS    9000000
`define RETRY_DEFAULT     6'h05
`define RETRY_MIN         6'h01
`define DLY_MIN           8'h02
`define UNIT_MAX          4'hF
`define DOT_CHAR          8'h2E
`define PKT_DATA          2'h0
`define PKT_ACK           2'h1
`define PKT_PING          2'h2
`define PKT_CFG           2'h3
`define CMD_BAUD          3'h0
`define CMD_UNIT          3'h1
`define CMD_SITE          3'h2
`define CMD_SHDN          3'h3
`define CMD_FLOW          3'h4
`define CMD_DLY           3'h5
`define CMD_RETRY         3'h6
`define CMD_STRT          3'h7
`endif

/* modem_net_pkg.sv */
// types shared by the modem network block
package modem_net_pkg;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_FILL = 3'h1,
      TX_SEND = 3'h3,
      TX_WAIT = 3'h2,
      TX_GAP  = 3'h6
   } tx_state_e;
   typedef logic [7:0] byte_t;
endpackage

/* stream_if.sv */
// valid/ready byte stream carrier between block modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* byte_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic flush_i,
   stream_if.snk     wr,
   stream_if.src     rd,
   output logic      full_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   wire do_wr = wr.valid && wr.ready;
   wire do_rd = rd.valid && rd.ready;
   // full and empty straight from the fill count
   assign wr.ready = (cnt_r != D[AW:0]);
   assign rd.valid = (cnt_r != '0);
   assign rd.data  = mem_r[rp_r];
   assign full_o   = !wr.ready;
   // pointers wrap by compare since depth need not be a power of two
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (flush_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (do_wr) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         if (do_rd) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
   // storage
   always_ff @(posedge clk_i) begin
      if (do_wr) mem_r[wp_r] <= wr.data;
   end
endmodule

/* modem_net_ctrl.sv */
// packet, addressing, remote config and range test control of the modem
//------------------------------------------------------------
//------------------------------------------------------------
`include "modem_net_map.svh"
`timescale 1ns/1ps
module modem_net_ctrl
   import modem_net_pkg::*;
#(
   parameter int DEPTH      = 32,
   parameter int TICK_CYC   = (`TICK_10MS_NS * `CLK_MHZ) / 1000,
   parameter int ACK_TO_CYC = 4 * TICK_CYC,
   parameter int SLOT_CYC   = (`SLOT_GAP_NS * `CLK_MHZ) / 1000,
   parameter int LOW_CYC    = (`LOW_AIR_GAP_NS * `CLK_MHZ) / 1000,
   parameter logic [15:0] SERIAL = 16'h1234 // arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  air_rate_setting_i,
   input  wire logic        ack_mode_i,
   input  wire logic        remote_en_i,
   input  wire logic        in_config_i,
   input  wire logic [2:0]  site_i,
   input  wire logic [3:0]  stored_unit_i,
   input  wire logic        host_valid_i,
   input  wire logic [7:0]  host_data_i,
   output logic             host_ready_o,
   output logic             host_tx_valid_o,
   output logic [7:0]       host_tx_data_o,
   input  wire logic        host_tx_ready_i,
   input  wire logic        addr_cmd_i,
   input  wire logic [3:0]  addr_unit_i,
   output logic             config_exit_o,
   output logic [3:0]       dest_unit_o,
   input  wire logic        rcmd_i,
   input  wire logic [15:0] rcmd_serial_i,
   input  wire logic [2:0]  rcmd_code_i,
   input  wire logic        rcmd_has_par_i,
   input  wire logic [7:0]  rcmd_par_i,
   input  wire logic        radar_start_i,
   input  wire logic        radar_stop_i,
   output logic             radar_active_o,
   output logic [15:0]      radar_ok_o,
   output logic             air_tx_valid_o,
   output logic [1:0]       air_tx_type_o,
   output logic [7:0]       air_tx_data_o,
   output logic [2:0]       air_tx_site_o,
   output logic [3:0]       air_tx_unit_o,
   input  wire logic        air_tx_ready_i,
   input  wire logic        air_rx_valid_i,
   input  wire logic        air_rx_crc_ok_i,
   input  wire logic [1:0]  air_rx_type_i,
   input  wire logic [2:0]  air_rx_site_i,
   input  wire logic [3:0]  air_rx_unit_i,
   input  wire logic [7:0]  air_rx_data_i,
   input  wire logic [15:0] air_rx_serial_i,
   input  wire logic [2:0]  air_rx_code_i,
   input  wire logic        air_rx_has_par_i,
   output logic             cfg_we_o,
   output logic [2:0]       cfg_code_o,
   output logic [7:0]       cfg_val_o,
   input  wire logic [7:0]  cfg_cur_i,
   output logic             link_lost_o
);
   //------------------------------------------------------------
   // transmit buffer
   //------------------------------------------------------------
   stream_if #(.W(8)) fin ();
   stream_if #(.W(8)) fout ();
   logic fifo_full;
   logic purge;
   assign fin.valid    = host_valid_i;
   assign fin.data     = host_data_i;
   assign host_ready_o = fin.ready;
   byte_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (purge),
      .wr      (fin),
      .rd      (fout),
      .full_o  (fifo_full)
   );

   //------------------------------------------------------------
   // working settings
   //------------------------------------------------------------
   logic [3:0]  dest_r;
   logic        dest_set_r;
   logic [5:0]  retry_lim_r;
   logic [7:0]  dly_r;
   // dynamic address overrides the stored unit but never writes it back
   assign dest_unit_o = dest_set_r ? dest_r : stored_unit_i;
   wire addr_ok = addr_cmd_i && (addr_unit_i <= `UNIT_MAX);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dest_r     <= '0;
         dest_set_r <= 1'b0;
      end else if (addr_ok) begin
         dest_r     <= addr_unit_i;
         dest_set_r <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // remote config check and apply
   //------------------------------------------------------------
   // range checks for the remotely changeable settings
   logic par_ok;
   always_comb begin
      unique case (air_rx_code_i)
         `CMD_UNIT:  par_ok = air_rx_data_i <= 8'h0F;
         `CMD_SITE:  par_ok = air_rx_data_i <= 8'h07;
         `CMD_DLY:   par_ok = air_rx_data_i >= {2'h0, `RETRY_MIN} + 8'h01;
         `CMD_RETRY: par_ok = air_rx_data_i >= 8'h01 && air_rx_data_i <= 8'h3F;
         `CMD_BAUD:  par_ok = air_rx_data_i <= 8'h08;
         default:    par_ok = air_rx_data_i <= 8'h01; // on/off, hw/none
      endcase
   end
   wire rx_good  = air_rx_valid_i && air_rx_crc_ok_i;
   wire addr_hit = (air_rx_site_i == site_i) && (air_rx_unit_i == stored_unit_i);
   wire cfg_hit  = rx_good && air_rx_type_i == `PKT_CFG && remote_en_i
                   && air_rx_serial_i == SERIAL;
   wire cfg_wr   = cfg_hit && air_rx_has_par_i && par_ok;
   wire cfg_rd   = cfg_hit && !air_rx_has_par_i;
   assign cfg_we_o   = cfg_wr;
   assign cfg_code_o = air_rx_code_i;
   assign cfg_val_o  = air_rx_data_i;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         retry_lim_r <= `RETRY_DEFAULT;
         dly_r       <= `DLY_MIN;
      end else if (cfg_wr && air_rx_code_i == `CMD_RETRY) begin
         retry_lim_r <= air_rx_data_i[5:0];
      end else if (cfg_wr && air_rx_code_i == `CMD_DLY) begin
         dly_r <= air_rx_data_i;
      end
   end

   //------------------------------------------------------------
   // receive path
   //------------------------------------------------------------
   wire rx_mine  = rx_good && addr_hit;
   wire rx_data  = rx_mine && air_rx_type_i == `PKT_DATA;
   wire rx_ack   = rx_mine && air_rx_type_i == `PKT_ACK;
   wire rx_ping  = rx_mine && air_rx_type_i == `PKT_PING;
   wire ack_need = (rx_data && ack_mode_i) || (rx_ping && !in_config_i);
   // one-byte host return register, dot has priority over delivered data
   logic       htx_v_r;
   logic [7:0] htx_d_r;
   assign host_tx_valid_o = htx_v_r;
   assign host_tx_data_o  = htx_d_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         htx_v_r <= 1'b0;
         htx_d_r <= '0;
      end else if (addr_ok) begin
         htx_v_r <= 1'b1;
         htx_d_r <= `DOT_CHAR;
      end else if (cfg_rd) begin
         htx_v_r <= 1'b1;
         htx_d_r <= cfg_cur_i;
      end else if (rx_data && (!htx_v_r || host_tx_ready_i)) begin
         htx_v_r <= 1'b1;
         htx_d_r <= air_rx_data_i;
      end else if (host_tx_ready_i) begin
         htx_v_r <= 1'b0;
      end
   end
   assign config_exit_o = addr_ok;

   //------------------------------------------------------------
   // range test
   //------------------------------------------------------------
   logic        radar_r;
   logic [15:0] ok_r;
   wire radar_ack = radar_r && rx_ack;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         radar_r <= 1'b0;
         ok_r    <= '0;
      end else begin
         if (radar_stop_i || host_valid_i) radar_r <= 1'b0;
         else if (radar_start_i) radar_r <= 1'b1;
         if (radar_start_i && !radar_r) ok_r <= '0;
         else if (radar_ack) ok_r <= ok_r + 16'h0001;
      end
   end
   assign radar_active_o = radar_r;
   assign radar_ok_o     = ok_r;

   //------------------------------------------------------------
   // transmit sequencer
   //------------------------------------------------------------
   tx_state_e   st_r;
   tx_state_e   st_nxt;
   logic [31:0] tmr_r;
   logic [7:0]  ticks_r;
   logic [5:0]  tries_r;
   logic        ack_pend_r;
   localparam int LW = $clog2(DEPTH) + 1;
   logic [7:0]    pkt_mem_r [DEPTH];
   logic [LW-1:0] pkt_len_r;
   logic [LW-1:0] rep_idx_r;
   logic          resend_r;
   logic          ping_wait_r;
   logic [31:0]   ping_tmr_r;
   // gap per air rate; max rate sends back to back
   wire [31:0] gap_cyc = (air_rate_setting_i == `RATE_SLOTS)   ? 32'(SLOT_CYC) :
                         (air_rate_setting_i == `RATE_LOW_AIR) ? 32'(LOW_CYC)  :
                         32'h0000_0001;
   // delay ticks only while filling, so wait and gap counts run through
   wire tick      = (st_r == TX_FILL) && (tmr_r == 32'(TICK_CYC - 1));
   wire dly_done  = tick && (ticks_r + 8'h01 >= dly_r);
   wire send_go   = fifo_full || dly_done;
   wire acked     = rx_ack && !radar_r;
   wire timed_out = (tmr_r == 32'(ACK_TO_CYC - 1));
   wire exhausted = timed_out && (tries_r >= retry_lim_r);
   wire sending   = (st_r == TX_SEND);
   // a resend replays the stored copy, since the fifo has already let it go
   wire pkt_cap   = (pkt_len_r == LW'(DEPTH));
   wire body_v    = resend_r ? (rep_idx_r != pkt_len_r) : (fout.valid && !pkt_cap);
   wire send_done = !body_v;
   wire pop       = sending && body_v && !ack_pend_r && air_tx_ready_i;
   // range requests wait for the reply or the ack timeout before the next
   wire ping_v    = radar_r && !ping_wait_r && !sending;
   wire ping_sent = ping_v && !ack_pend_r && air_tx_ready_i;
   wire ping_to   = ping_wait_r && (ping_tmr_r == 32'(ACK_TO_CYC - 1));
   // acks outrank data so the peer is not left waiting
   assign air_tx_valid_o = ack_pend_r || (sending && body_v) || ping_v;
   assign air_tx_type_o  = ack_pend_r ? `PKT_ACK : ping_v ? `PKT_PING : `PKT_DATA;
   assign air_tx_data_o  = resend_r ? pkt_mem_r[rep_idx_r[LW-2:0]] : fout.data;
   assign air_tx_site_o  = site_i;
   assign air_tx_unit_o  = dest_unit_o;
   // the buffer drains as one packet, capped at the copy depth
   assign fout.ready = pop && !resend_r;
   assign purge      = (st_r == TX_WAIT) && exhausted;
   assign link_lost_o = purge;
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         TX_IDLE: if (fout.valid) st_nxt = TX_FILL;
         TX_FILL: if (send_go) st_nxt = TX_SEND;
         TX_SEND: if (send_done) st_nxt = ack_mode_i ? TX_WAIT : TX_GAP;
         TX_WAIT: begin
            if (acked) st_nxt = TX_GAP;
            else if (exhausted) st_nxt = TX_IDLE;
            else if (timed_out) st_nxt = TX_SEND;
         end
         TX_GAP:  if (tmr_r + 32'h1 >= gap_cyc) st_nxt = TX_IDLE;
         default: st_nxt = TX_IDLE;
      endcase
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r       <= TX_IDLE;
         tmr_r      <= '0;
         ticks_r    <= '0;
         tries_r    <= '0;
         ack_pend_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         tmr_r   <= (st_nxt != st_r || tick) ? '0 : tmr_r + 32'h1;
         ticks_r <= (st_r != TX_FILL) ? '0 : tick ? ticks_r + 8'h01 : ticks_r;
         if (st_r == TX_FILL) tries_r <= '0;
         else if (st_r == TX_WAIT && timed_out) tries_r <= tries_r + 6'h01;
         if (ack_need) ack_pend_r <= 1'b1;
         else if (air_tx_ready_i) ack_pend_r <= 1'b0;
      end
   end
   // packet copy bookkeeping, filled as the first pass leaves the fifo
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pkt_len_r <= '0;
         rep_idx_r <= '0;
         resend_r  <= 1'b0;
      end else begin
         if (st_r == TX_FILL) pkt_len_r <= '0;
         else if (pop && !resend_r) pkt_len_r <= pkt_len_r + LW'(1);
         if (st_r != TX_SEND) rep_idx_r <= '0;
         else if (pop && resend_r) rep_idx_r <= rep_idx_r + LW'(1);
         if (st_r == TX_FILL) resend_r <= 1'b0;
         else if (st_r == TX_WAIT && timed_out) resend_r <= 1'b1;
      end
   end
   // copy storage needs no reset, only bytes below the length are read
   always_ff @(posedge clk_i) begin
      if (pop && !resend_r) pkt_mem_r[pkt_len_r[LW-2:0]] <= fout.data;
   end
   // one range request in flight at a time
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ping_wait_r <= 1'b0;
         ping_tmr_r  <= '0;
      end else begin
         if (!radar_r || radar_ack || ping_to) ping_wait_r <= 1'b0;
         else if (ping_sent) ping_wait_r <= 1'b1;
         ping_tmr_r <= ping_wait_r ? ping_tmr_r + 32'h1 : '0;
      end
   end
endmodule

/* modem_net_monitor.sv */
// port-level assertions for the modem network control block
`timescale 1ns/1ps
`include "modem_net_map.svh"
module modem_net_monitor #(
   parameter logic [15:0] SERIAL = 16'h1234 // arbitrary value
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        addr_cmd_i,
   input wire logic [3:0]  addr_unit_i,
   input wire logic        config_exit_o,
   input wire logic [3:0]  dest_unit_o,
   input wire logic        host_tx_valid_o,
   input wire logic [7:0]  host_tx_data_o,
   input wire logic        host_valid_i,
   input wire logic        cfg_we_o,
   input wire logic [2:0]  cfg_code_o,
   input wire logic [7:0]  cfg_val_o,
   input wire logic        air_rx_valid_i,
   input wire logic        air_rx_crc_ok_i,
   input wire logic [15:0] air_rx_serial_i,
   input wire logic        air_rx_has_par_i,
   input wire logic        remote_en_i,
   input wire logic        radar_active_o,
   input wire logic [15:0] radar_ok_o,
   input wire logic        link_lost_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   // address switch must not touch the stored unit
   addr_exit_a: assert property (addr_cmd_i |-> config_exit_o && !cfg_we_o)
      else $error("address command did not leave config cleanly");
   dot_out_a: assert property (addr_cmd_i |=> host_tx_valid_o && host_tx_data_o == `DOT_CHAR)
      else $error("no dot after address command");
   dest_set_a: assert property (addr_cmd_i |=> dest_unit_o == $past(addr_unit_i))
      else $error("destination unit not taken");
   crc_drop_a: assert property (air_rx_valid_i && !air_rx_crc_ok_i |-> !cfg_we_o ##1 !$rose(host_tx_valid_o))
      else $error("corrupt packet acted on");
   remote_off_a: assert property (air_rx_valid_i && !remote_en_i |-> !cfg_we_o)
      else $error("remote setting applied while disabled");
   serial_match_a: assert property (cfg_we_o |-> air_rx_valid_i && air_rx_serial_i == SERIAL && air_rx_has_par_i)
      else $error("setting applied without serial match");
   retry_range_a: assert property (cfg_we_o && cfg_code_o == `CMD_RETRY |-> cfg_val_o inside {[8'h01:8'h3F]})
      else $error("retry count out of range");
   site_range_a: assert property (cfg_we_o && cfg_code_o == `CMD_SITE |-> cfg_val_o <= 8'h07)
      else $error("site code out of range");
   radar_stop_a: assert property (radar_active_o && host_valid_i |=> !radar_active_o)
      else $error("range test not ended by host byte");
   ok_step_a: assert property (radar_ok_o != $past(radar_ok_o) |-> radar_ok_o == $past(radar_ok_o) + 16'h0001)
      else $error("success count jumped");
   cfg_c: cover property (cfg_we_o);
   lost_c: cover property (link_lost_o);
   addr_c: cover property (addr_cmd_i ##1 host_tx_valid_o);
endmodule
bind modem_net_ctrl modem_net_monitor #(.SERIAL(SERIAL)) mon (.*);

/* host_model.sv */
// host controller model on the modem's byte ports
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_i,
   input  wire logic       ready_i,
   output logic            valid_o,
   output logic [7:0]      data_o,
   input  wire logic       rx_valid_i,
   input  wire logic [7:0] rx_data_i,
   output logic            rx_ready_o
);
   int         n_rx = 0;
   logic [7:0] last = 8'h00;
   initial begin
      valid_o = 1'b0;
      data_o = 8'hFF;
      rx_ready_o = 1'b1;
   end
   // hold the byte until taken; idle data inverted so no stale match
   task put(input logic [7:0] b);
      @(posedge clk_i);
      #1 valid_o = 1'b1;
      data_o = b;
      do @(posedge clk_i); while (!ready_i);
      #1 valid_o = 1'b0;
      data_o = ~b;
   endtask
   always @(posedge clk_i) begin
      if (rx_valid_i && rx_ready_o) begin
         n_rx <= n_rx + 1;
         last <= rx_data_i;
      end
   end
endmodule

/* radio_modem_network_config_tb.sv */
// self-checking bench for the modem network control block
`timescale 1ns/1ps
`include "modem_net_map.svh"
module radio_modem_network_config_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, ack_mode_i = 1'b1, remote_en_i = 1'b1, in_config_i = 1'b0;
   logic [1:0] air_rate_setting_i = 2'h0, air_rx_type_i = 2'h0, air_tx_type_o;
   logic [2:0] site_i = 3'h5, air_rx_site_i = 3'h5, rcmd_code_i = 3'h0, air_rx_code_i = 3'h0;
   logic [3:0] stored_unit_i = 4'h3, addr_unit_i = 4'h0, air_rx_unit_i = 4'h0;
   logic [7:0] host_data_i, rcmd_par_i = 8'h00, air_rx_data_i = 8'h00, cfg_cur_i = 8'h2A;
   logic [15:0] rcmd_serial_i = 16'h0000, air_rx_serial_i = 16'h1234, radar_ok_o;
   logic host_valid_i, host_ready_o, host_tx_valid_o, host_tx_ready_i, addr_cmd_i = 1'b0;
   logic rcmd_i = 1'b0, rcmd_has_par_i = 1'b0, radar_start_i = 1'b0, radar_stop_i = 1'b0;
   logic air_tx_ready_i = 1'b1, air_rx_valid_i = 1'b0, air_rx_crc_ok_i = 1'b0;
   logic air_rx_has_par_i = 1'b1, config_exit_o, radar_active_o, air_tx_valid_o;
   logic cfg_we_o, link_lost_o, we_s;
   logic [7:0] host_tx_data_o, air_tx_data_o, cfg_val_o, val_s;
   logic [2:0] air_tx_site_o, cfg_code_o, code_s;
   logic [3:0] dest_unit_o, air_tx_unit_o;
   int n_fail = 0, compares = 0, cyc = 0, n_lost = 0, n_air[4] = '{0, 0, 0, 0}, a0, d0, h0;
   logic [13:0] tbl [15] = '{14'h390F, 14'h3A07, 14'h3B01, 14'h3C00, 14'h3D02, 14'h3E3F,
      14'h3F01, 14'h1910, 14'h1A08, 14'h1D01, 14'h1E00, 14'h1E40, 14'h1105, 14'h0905,
      14'h3E05};
   modem_net_ctrl #(.TICK_CYC(10), .ACK_TO_CYC(40), .SLOT_CYC(20), .LOW_CYC(30)) dut (.*);
   host_model hm (.clk_i(clk_i), .ready_i(host_ready_o), .valid_o(host_valid_i),
      .data_o(host_data_i), .rx_valid_i(host_tx_valid_o), .rx_data_i(host_tx_data_o),
      .rx_ready_o(host_tx_ready_i));
   always #2 clk_i = ~clk_i;
   // air traffic tally and hang guard
   always @(posedge clk_i) begin
      if (air_tx_valid_o && air_tx_ready_i) n_air[air_tx_type_o] <= n_air[air_tx_type_o] + 1;
      if (link_lost_o) n_lost <= n_lost + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // one received packet; settings strobe sampled before its edge
   task rx(input logic [1:0] t, input logic c, input logic [3:0] u, input logic [7:0] d);
      air_rx_type_i = t;
      air_rx_crc_ok_i = c;
      air_rx_unit_i = u;
      air_rx_data_i = d;
      air_rx_valid_i = 1'b1;
      #1 we_s = cfg_we_o;
      code_s = cfg_code_o;
      val_s = cfg_val_o;
      @(posedge clk_i);
      #1 air_rx_valid_i = 1'b0;
      air_rx_data_i = ~d;
   endtask
   task tally_and_finish();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      tick(8);
      rst_i = 1'b0;
      chk(dest_unit_o, 16'h3);
      //------------------------------------------------------------
      // dynamic address switch
      //------------------------------------------------------------
      addr_unit_i = 4'h9;
      addr_cmd_i = 1'b1;
      rcmd_i = 1'b1;
      #1 chk(config_exit_o, 1'b1);
      tick(1);
      addr_cmd_i = 1'b0;
      rcmd_i = 1'b0;
      tick(3);
      chk(dest_unit_o, 16'h9);
      chk(hm.last, `DOT_CHAR);
      //------------------------------------------------------------
      // remote settings: legal, out of range, wrong serial, disabled
      //------------------------------------------------------------
      for (int i = 0; i < 15; i++) begin
         remote_en_i = tbl[i][12];
         air_rx_serial_i = tbl[i][11] ? 16'h1234 : 16'h4321;
         air_rx_code_i = tbl[i][10:8];
         rx(`PKT_CFG, 1'b1, 4'h3, tbl[i][7:0]);
         chk(we_s, tbl[i][13]);
         if (tbl[i][13]) chk({code_s, val_s}, tbl[i][10:0]);
         tick(2);
      end
      remote_en_i = 1'b1;
      air_rx_serial_i = 16'h1234;
      air_rx_has_par_i = 1'b0;
      rx(`PKT_CFG, 1'b1, 4'h3, 8'h00);
      tick(4);
      chk(we_s, 1'b0);
      chk(hm.last, 8'h2A);
      //------------------------------------------------------------
      // received data: corrupt, foreign site, acked, ack off, pings
      //------------------------------------------------------------
      h0 = hm.n_rx;
      a0 = n_air[1];
      rx(`PKT_DATA, 1'b0, 4'h3, 8'h55);
      air_rx_site_i = 3'h4;
      rx(`PKT_DATA, 1'b1, 4'h3, 8'h55);
      air_rx_site_i = 3'h5;
      tick(10);
      chk(hm.n_rx - h0, 16'h0);
      chk(n_air[1] - a0, 16'h0);
      rx(`PKT_DATA, 1'b1, 4'h3, 8'h66);
      tick(10);
      chk(hm.last, 8'h66);
      chk(n_air[1] - a0, 16'h1);
      ack_mode_i = 1'b0;
      rx(`PKT_DATA, 1'b1, 4'h3, 8'h77);
      tick(10);
      ack_mode_i = 1'b1;
      chk(hm.last, 8'h77);
      in_config_i = 1'b1;
      rx(`PKT_PING, 1'b1, 4'h3, 8'h00);
      tick(10);
      in_config_i = 1'b0;
      chk(n_air[1] - a0, 16'h1);
      rx(`PKT_PING, 1'b1, 4'h3, 8'h00);
      tick(10);
      chk(n_air[1] - a0, 16'h2);
      //------------------------------------------------------------
      // range test, then the ending byte goes out unanswered
      //------------------------------------------------------------
      a0 = n_air[2];
      radar_start_i = 1'b1;
      tick(1);
      radar_start_i = 1'b0;
      tick(5);
      chk(n_air[2] - a0, 16'h1);
      rx(`PKT_ACK, 1'b1, 4'h3, 8'h00);
      tick(50);
      chk(radar_ok_o, 16'h1);
      chk(n_air[2] - a0 > 1, 1'b1);
      air_rate_setting_i = `RATE_SLOTS;
      d0 = n_air[0];
      hm.put(8'hA5);
      tick(2);
      chk(radar_active_o, 1'b0);
      tick(13);
      chk(n_air[0] - d0, 16'h0);
      air_tx_ready_i = 1'b0;
      tick(20);
      air_tx_ready_i = 1'b1;
      for (int k = 0; k < 2000 && n_lost == 0; k++) tick(1);
      chk(n_lost, 16'h1);
      chk(n_air[0] - d0, 16'h6);
      tally_and_finish();
   end
endmodule
